// *** logic/pllcb_bank.sv ***
// Synthesizer control register bank written over the serial link
// Operation
// RULE1: Control code 100 loads charge pump register
// RULE2: Bit 18 picks internal or external resistor
// RULE3: Pump multiplier is one plus bits 11:10
// RULE4: Bits 16:12 set detector phase offset
// RULE5: Bit 17 sets phase offset sign
// RULE6: Reference scales by two, one, half, quarter
// RULE7: Mux output selectable, lock detect after reset
// RULE8: Lock detect drives high while locked
// RULE9: Register five holds LO direction, divider, bias
// RULE10: External LO divided by two or four
// RULE11: Host sets pin and bits for external LO
// RULE12: Control code 110 loads VCO register
// RULE13: Band source: calibration or serial band value
// RULE14: VCO amplitude 0 to 31, resets to 24
// RULE15: Separate VCO and regulator disable bits
// RULE16: Charge pump enable, enabled by default
// RULE17: Loop frequency is detector times 2(INT+FRAC/modulus)
// RULE18: Host keeps integer ratio at most 119
// RULE19: Internal VCO LO is loop frequency over four
// RULE20: 24-bit word, low three bits select register
// RULE21: Writes to registers 0-2 start VCO calibration
// RULE22: Host writes downward, register six first
// RULE23: Shift MSB first, latch on rising enable
`timescale 1ns/10ps
`default_nettype none
module pllcb_bank (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Serial pins from the host
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        latch_enable_line,
  // Analog status and strap pins
  input  wire logic        loop_locked,
  input  wire logic [5:0]  band_calibration,
  input  wire logic        lo_source_select_pin,
  // Multiplexed output pin
  output logic             mux_output_pin,
  // Charge pump and reference controls
  output logic             cp_use_current_set_resistor,
  output logic [2:0]       cp_current_mult,
  output logic [4:0]       det_phase_offset,
  output logic             det_phase_offset_neg,
  output logic [1:0]       ref_scale_sel,
  // LO path and demodulator controls
  output logic             lo_drive_bit,
  output logic             external_lo_bit,
  output logic             lo_path_divider_bit,
  output logic             lo_pre_poly_div2,
  output logic             demod_bias_en,
  output logic             external_lo_active,
  output logic [2:0]       lo_mixer_divide,
  // VCO controls
  output logic [5:0]       vco_band,
  output logic [4:0]       vco_amplitude,
  output logic             vco_en,
  output logic             voltage_regulator_en,
  output logic             cp_en,
  // Frequency plan
  output logic [6:0]       int_ratio,
  output logic [10:0]      modulus_value,
  output logic [10:0]      frac_value,
  output logic [19:0]      pll_ratio_num,
  output logic             vco_cal_start
);

  // Word carrier from the receiver
  pllcb_word_if word_bus ();

  // Receiver: pin sync, shifting and latch detection
  pllcb_serial_rx u_rx (
    .clk               (clk),
    .rst_n             (rst_n),
    .ser_clk           (ser_clk),
    .ser_data          (ser_data),
    .latch_enable_line (latch_enable_line),
    .word_o            (word_bus.src)
  );

  // Status pin synchronisers
  // Every pin passes two flops before use
  // Band word is quasi-static, so no handshake
  logic       lock_s1_q, lock_s1_d;   // First stage, read only by second
  logic       lock_s2_q, lock_s2_d;   // Safe lock level
  logic       losrc_s1_q, losrc_s1_d; // First stage
  logic       losrc_s2_q, losrc_s2_d; // Safe select pin level
  logic [5:0] band_s1_q, band_s1_d;   // First stage
  logic [5:0] band_s2_q, band_s2_d;   // Calibrated band, quasi-static

  // Next values of the synchronisers
  always_comb begin
    lock_s1_d  = loop_locked;
    lock_s2_d  = lock_s1_q;
    // Pins move one stage per edge
    losrc_s1_d = lo_source_select_pin;
    losrc_s2_d = losrc_s1_q;
    band_s1_d  = band_calibration;
    band_s2_d  = band_s1_q;
  end

  // Synchroniser flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle levels: unlocked, select pin low, band zero
      lock_s1_q  <= 1'b0;
      lock_s2_q  <= 1'b0;
      losrc_s1_q <= 1'b0;
      losrc_s2_q <= 1'b0;
      band_s1_q  <= 6'h00;
      band_s2_q  <= 6'h00;
    end else begin
      // Stage two reads only stage one
      lock_s1_q  <= lock_s1_d;
      lock_s2_q  <= lock_s2_d;
      losrc_s1_q <= losrc_s1_d;
      losrc_s2_q <= losrc_s2_d;
      band_s1_q  <= band_s1_d;
      band_s2_q  <= band_s2_d;
    end
  end

  // Register storage and write decode
  // Whole words kept for codes 4 to 6; fields picked out later
  // Codes 3 and 7 belong elsewhere, dropped
  logic [23:0] cp_ref_q, cp_ref_d;     // Charge pump, detector, reference
  logic [23:0] lo_path_q, lo_path_d;   // LO path and demodulator
  logic [23:0] vco_q, vco_d;           // VCO control and enables
  logic [6:0]  int_q, int_d;           // Integer ratio
  logic [10:0] mod_q, mod_d;           // Modulus
  logic [10:0] frac_q, frac_d;         // Fraction
  logic        cal_q, cal_d;           // Calibration start strobe
  logic [2:0]  ctrl;                   // Control field of the new word

  // Destination chosen by the control field
  always_comb begin
    // Control field sits in the low bits
    ctrl      = word_bus.word[pllcb_pkg::CTRL_W-1:0]; // RULE20
    // Hold every register and clear the strobe unless a word arrives
    cp_ref_d  = cp_ref_q;
    lo_path_d = lo_path_q;
    vco_d     = vco_q;
    int_d     = int_q;
    mod_d     = mod_q;
    frac_d    = frac_q;
    cal_d     = 1'b0;
    if (!word_bus.valid) begin
      // No word this cycle: hold every register, strobe low
      cal_d = 1'b0;
    end else if (ctrl == pllcb_pkg::ADDR_CP_REF) begin
      cp_ref_d = word_bus.word; // RULE1
    end else if (ctrl == pllcb_pkg::ADDR_LO_PATH) begin
      lo_path_d = word_bus.word; // RULE9
    end else if (ctrl == pllcb_pkg::ADDR_VCO) begin
      vco_d = word_bus.word; // RULE12
    end else if (ctrl == pllcb_pkg::ADDR_R0) begin
      // Equal rewrite still calibrates
      int_d = word_bus.word[pllcb_pkg::INT_LSB +: pllcb_pkg::INT_W];
      cal_d = 1'b1; // RULE21
    end else if (ctrl == pllcb_pkg::ADDR_R1) begin
      // Modulus word
      mod_d = word_bus.word[pllcb_pkg::MOD_LSB +: pllcb_pkg::MOD_W];
      cal_d = 1'b1; // RULE21
    end else if (ctrl == pllcb_pkg::ADDR_R2) begin
      // Fraction word
      frac_d = word_bus.word[pllcb_pkg::FRAC_LSB +: pllcb_pkg::FRAC_W];
      cal_d  = 1'b1; // RULE21
    end else begin
      // Other codes belong to registers outside this bank
      cal_d = 1'b0;
    end
  end

  // Storage flops; rewrite of an equal value still strobes calibration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Idle register words
      cp_ref_q  <= pllcb_pkg::CP_REF_RST;
      lo_path_q <= pllcb_pkg::LO_PATH_RST;
      vco_q     <= pllcb_pkg::VCO_RST;
      int_q     <= pllcb_pkg::INT_RST;
      mod_q     <= pllcb_pkg::MOD_RST;
      frac_q    <= pllcb_pkg::FRAC_RST;
      cal_q     <= 1'b0;
    end else begin
      // Plain load on every edge
      cp_ref_q  <= cp_ref_d;
      lo_path_q <= lo_path_d;
      vco_q     <= vco_d;
      int_q     <= int_d;
      mod_q     <= mod_d;
      frac_q    <= frac_d;
      cal_q     <= cal_d;
    end
  end

  // Output stage: every control leaves from a flop
  // A cycle of latency buys glitch-free pins
  // Reset values hold until the first edge
  logic        mux_q, mux_d;           // Multiplexed pin level
  logic        cp_src_q, cp_src_d;     // Resistor choice
  logic [2:0]  cpm_q, cpm_d;           // Pump multiplier 1..4
  logic [4:0]  ofs_q, ofs_d;           // Phase offset magnitude
  logic        ofs_neg_q, ofs_neg_d;   // Phase offset sign
  logic [1:0]  ref_q, ref_d;           // Reference scale code
  logic [4:0]  lo_bits_q, lo_bits_d;   // Drive, ext, div, prediv, bias
  logic        ext_act_q, ext_act_d;   // External LO in use
  logic [2:0]  lodiv_q, lodiv_d;       // Divide ahead of the mixer
  logic [5:0]  band_q, band_d;         // Band actually used
  logic [4:0]  amp_q, amp_d;           // VCO amplitude
  logic        vco_en_q, vco_en_d;     // VCO running
  logic        reg_en_q, reg_en_d;     // Regulator running
  logic        cp_en_q, cp_en_d;       // Pump running
  logic [19:0] ratio_q, ratio_d;       // 2*(INT*modulus+FRAC)
  logic [17:0] int_mod;                // Product term
  logic [2:0]  mux_sel;                // Multiplexer code

  // Derived control values
  always_comb begin
    // Select code in the top three bits
    mux_sel = cp_ref_q[pllcb_pkg::MUX_LSB +: 3];
    // Pin choice; reset code selects the lock indication
    case (mux_sel)
      pllcb_pkg::MUX_LOCK:   mux_d = lock_s2_q;  // RULE7 RULE8
      pllcb_pkg::MUX_LOW:    mux_d = 1'b0;
      pllcb_pkg::MUX_HIGH:   mux_d = 1'b1;
      pllcb_pkg::MUX_EXT_LO: mux_d = ext_act_q;
      default:               mux_d = 1'b0;       // Unused codes park low
    endcase
    // Pump, detector and reference fields
    cp_src_d  = cp_ref_q[pllcb_pkg::CP_SRC_BIT]; // RULE2
    cpm_d     = 3'(cp_ref_q[pllcb_pkg::CPM_LSB +: 2]) + 3'h1; // RULE3
    ofs_d     = cp_ref_q[pllcb_pkg::OFS_LSB +: pllcb_pkg::OFS_W]; // RULE4
    ofs_neg_d = cp_ref_q[pllcb_pkg::OFS_SIGN_BIT]; // RULE5
    ref_d     = cp_ref_q[pllcb_pkg::REF_LSB +: 2]; // RULE6
    // LO path bits, held as one group
    lo_bits_d = {lo_path_q[pllcb_pkg::DEMOD_BIAS_BIT],
                 lo_path_q[pllcb_pkg::PRE_DIV_BIT],
                 lo_path_q[pllcb_pkg::LO_DIV_BIT],
                 lo_path_q[pllcb_pkg::LO_EXT_BIT],
                 lo_path_q[pllcb_pkg::LO_DRV_BIT]}; // RULE9
    // External path only when pin low, drive low, external high
    ext_act_d = ~losrc_s2_q & ~lo_path_q[pllcb_pkg::LO_DRV_BIT]
                & lo_path_q[pllcb_pkg::LO_EXT_BIT]; // RULE11
    // External LO: by 2 or 4; internal VCO: always by 4
    if (ext_act_d) begin
      lodiv_d = lo_path_q[pllcb_pkg::LO_DIV_BIT] ? pllcb_pkg::LO_DIV_BY4
                                                  : pllcb_pkg::LO_DIV_BY2; // RULE10
    end else begin
      lodiv_d = pllcb_pkg::LO_DIV_BY4; // RULE19
    end
    // Band from calibration unless the serial value is chosen
    if (vco_q[pllcb_pkg::BAND_SRC_BIT]) begin
      band_d = vco_q[pllcb_pkg::BAND_LSB +: pllcb_pkg::BAND_W]; // RULE13
    end else begin
      band_d = band_s2_q; // RULE13
    end
    // VCO and regulator bits are disables
    amp_d    = vco_q[pllcb_pkg::AMP_LSB +: pllcb_pkg::AMP_W]; // RULE14
    vco_en_d = ~vco_q[pllcb_pkg::VCO_OFF_BIT]; // RULE15
    reg_en_d = ~vco_q[pllcb_pkg::REG_OFF_BIT]; // RULE15
    cp_en_d  = vco_q[pllcb_pkg::CP_EN_BIT]; // RULE16
    // Ratio numerator over the modulus; fits for every 7-bit INT value
    int_mod = 18'(int_q) * 18'(mod_q); // RULE18
    // Factor two is the appended zero
    ratio_d = {19'(int_mod) + 19'(frac_q), 1'b0}; // RULE17
  end

  // Output flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Quiet levels while in reset
      mux_q     <= 1'b0;
      cp_src_q  <= 1'b0;
      cpm_q     <= 3'h1;
      ofs_q     <= 5'h00;
      ofs_neg_q <= 1'b0;
      ref_q     <= pllcb_pkg::REF_X1;
      lo_bits_q <= 5'h00;
      ext_act_q <= 1'b0;
      lodiv_q   <= pllcb_pkg::LO_DIV_BY4;
      band_q    <= 6'h00;
      amp_q     <= 5'h00;
      vco_en_q  <= 1'b0;
      reg_en_q  <= 1'b0;
      cp_en_q   <= 1'b0;
      ratio_q   <= 20'h0_0000;
    end else begin
      // Derived values trail storage by a cycle
      mux_q     <= mux_d;
      cp_src_q  <= cp_src_d;
      cpm_q     <= cpm_d;
      ofs_q     <= ofs_d;
      ofs_neg_q <= ofs_neg_d;
      ref_q     <= ref_d;
      lo_bits_q <= lo_bits_d;
      ext_act_q <= ext_act_d;
      lodiv_q   <= lodiv_d;
      band_q    <= band_d;
      amp_q     <= amp_d;
      vco_en_q  <= vco_en_d;
      reg_en_q  <= reg_en_d;
      cp_en_q   <= cp_en_d;
      ratio_q   <= ratio_d;
    end
  end

  // Port drive
  assign mux_output_pin              = mux_q;

  // Charge pump and reference
  assign cp_use_current_set_resistor = cp_src_q;
  assign cp_current_mult             = cpm_q;
  assign det_phase_offset            = ofs_q;
  assign det_phase_offset_neg        = ofs_neg_q;
  assign ref_scale_sel               = ref_q;

  // LO path
  assign lo_drive_bit                = lo_bits_q[0];
  assign external_lo_bit             = lo_bits_q[1];
  assign lo_path_divider_bit         = lo_bits_q[2];
  assign lo_pre_poly_div2            = lo_bits_q[3];
  assign demod_bias_en               = lo_bits_q[4];
  assign external_lo_active          = ext_act_q;
  assign lo_mixer_divide             = lodiv_q;
  // VCO
  assign vco_band                    = band_q;
  assign vco_amplitude               = amp_q;
  assign vco_en                      = vco_en_q;
  assign voltage_regulator_en        = reg_en_q;
  assign cp_en                       = cp_en_q;
  // Frequency plan
  assign int_ratio                   = int_q;
  assign modulus_value               = mod_q;
  assign frac_value                  = frac_q;
  assign pll_ratio_num               = ratio_q;
  assign vco_cal_start               = cal_q;
endmodule
`default_nettype wire

// *** shared/pllcb_pkg.sv ***
// Constants for the synthesizer control register bank
`default_nettype none
package pllcb_pkg;
  // Serial word layout
  localparam int WORD_W = 24;
  localparam int CTRL_W = 3;
  // Control field codes that pick the destination register
  localparam logic [2:0] ADDR_R0 = 3'h0;
  localparam logic [2:0] ADDR_R1 = 3'h1;
  localparam logic [2:0] ADDR_R2 = 3'h2;
  localparam logic [2:0] ADDR_CP_REF = 3'h4;
  localparam logic [2:0] ADDR_LO_PATH = 3'h5;
  localparam logic [2:0] ADDR_VCO = 3'h6;
  // Frequency word fields
  localparam int INT_LSB = 3;
  localparam int INT_W = 7;
  localparam int MOD_LSB = 3;
  localparam int MOD_W = 11;
  localparam int FRAC_LSB = 3;
  localparam int FRAC_W = 11;
  localparam int RATIO_W = 20;
  localparam logic [6:0] INT_RST = 7'h00;
  localparam logic [10:0] MOD_RST = 11'h600;
  localparam logic [10:0] FRAC_RST = 11'h000;
  // Charge pump and reference register fields
  localparam int CPM_LSB = 10;
  localparam int OFS_LSB = 12;
  localparam int OFS_W = 5;
  localparam int OFS_SIGN_BIT = 17;
  localparam int CP_SRC_BIT = 18;
  localparam int REF_LSB = 19;
  localparam int MUX_LSB = 21;
  localparam logic [23:0] CP_REF_RST = 24'h00_0004;
  // Output multiplexer codes
  localparam logic [2:0] MUX_LOCK = 3'h0;
  localparam logic [2:0] MUX_LOW = 3'h1;
  localparam logic [2:0] MUX_HIGH = 3'h2;
  localparam logic [2:0] MUX_EXT_LO = 3'h3;
  // Reference scale codes
  localparam logic [1:0] REF_X1 = 2'h0;
  localparam logic [1:0] REF_X2 = 2'h1;
  localparam logic [1:0] REF_HALF = 2'h2;
  localparam logic [1:0] REF_QUARTER = 2'h3;
  // LO path register fields
  localparam int LO_DRV_BIT = 3;
  localparam int LO_EXT_BIT = 4;
  localparam int LO_DIV_BIT = 5;
  localparam int PRE_DIV_BIT = 6;
  localparam int DEMOD_BIAS_BIT = 7;
  localparam logic [23:0] LO_PATH_RST = 24'h00_0005;
  // VCO register fields
  localparam int BAND_LSB = 3;
  localparam int BAND_W = 6;
  localparam int BAND_SRC_BIT = 9;
  localparam int AMP_LSB = 10;
  localparam int AMP_W = 5;
  localparam int VCO_OFF_BIT = 15;
  localparam int REG_OFF_BIT = 16;
  localparam int CP_EN_BIT = 17;
  localparam logic [23:0] VCO_RST = 24'h02_6006;
  // Divide ratios on the LO path
  localparam logic [2:0] LO_DIV_BY2 = 3'h2;
  localparam logic [2:0] LO_DIV_BY4 = 3'h4;
endpackage
`default_nettype wire

// *** shared/pllcb_word_if.sv ***
// Carrier for a latched serial word between receiver and register bank
`timescale 1ns/10ps
`default_nettype none
interface pllcb_word_if;
  logic        valid;  // One-cycle pulse per latched word
  logic [23:0] word;   // Word as shifted in, control field low
  modport src (output valid, output word);
  modport dst (input valid, input word);
endinterface
`default_nettype wire

// *** logic/pllcb_serial_rx.sv ***
// Serial word receiver: pin synchronisers, shifter and latch strobe
`timescale 1ns/10ps
`default_nettype none
module pllcb_serial_rx (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Serial pins from the host
  input  wire logic ser_clk,
  input  wire logic ser_data,
  input  wire logic latch_enable_line,
  // Latched words toward the bank
  pllcb_word_if.src word_o
);
  logic [2:0]  sclk_q, sclk_d;     // Two sync stages plus edge history
  logic [1:0]  sdat_q, sdat_d;     // Two sync stages
  logic [2:0]  ld_q, ld_d;         // Two sync stages plus edge history
  logic [23:0] shift_q, shift_d;   // Incoming bits, newest at bit 0
  logic [23:0] word_q, word_d;     // Last latched word
  logic        valid_q, valid_d;   // Latch strobe
  logic        sclk_rise;
  logic        ld_rise;

  // Next values; edges are judged only from stage two onward
  always_comb begin
    sclk_d    = {sclk_q[1:0], ser_clk};
    sdat_d    = {sdat_q[0], ser_data};
    ld_d      = {ld_q[1:0], latch_enable_line};
    sclk_rise = sclk_q[1] & ~sclk_q[2];
    ld_rise   = ld_q[1] & ~ld_q[2];
    shift_d   = shift_q;
    word_d    = word_q;
    valid_d   = 1'b0;
    // Most significant bit arrives first
    if (sclk_rise) begin
      shift_d = {shift_q[22:0], sdat_q[1]}; // RULE23
    end
    // Latch rise hands the word over; a coincident bit is kept
    if (ld_rise) begin
      word_d  = shift_d; // RULE23
      valid_d = 1'b1;
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_q  <= 3'h0;
      sdat_q  <= 2'h0;
      ld_q    <= 3'h0;
      shift_q <= 24'h00_0000;
      word_q  <= 24'h00_0000;
      valid_q <= 1'b0;
    end else begin
      sclk_q  <= sclk_d;
      sdat_q  <= sdat_d;
      ld_q    <= ld_d;
      shift_q <= shift_d;
      word_q  <= word_d;
      valid_q <= valid_d;
    end
  end

  assign word_o.valid = valid_q;
  assign word_o.word  = word_q;
endmodule
`default_nettype wire

// *** tb/pllcb_host_model.sv ***
// Host controller model that shifts serial words into the bank
`timescale 1ns/10ps
`default_nettype none
module pllcb_host_model (
  // Timing reference
  input  wire logic clk,
  // Serial pins toward the device
  output logic      ser_clk,
  output logic      ser_data,
  output logic      latch_enable_line
);
  // Link idles low, serial clock stands still outside frames
  initial begin
    ser_clk = 1'h0;
    ser_data = 1'h0;
    latch_enable_line = 1'h0;
  end
  // One word: 200 ns low, 200 ns high per bit, MSB first
  task automatic send(input logic [23:0] w);
    int i;
    for (i = 23; i >= 0; i--) begin
      @(posedge clk);
      ser_clk <= 1'h0;
      ser_data <= w[i];
      repeat (4) @(posedge clk);
      ser_clk <= 1'h1;
      repeat (3) @(posedge clk);
    end
    // Released data shows the inverse so stale bits are not read
    @(posedge clk);
    ser_clk <= 1'h0;
    ser_data <= ~w[0];
    repeat (3) @(posedge clk);
    // Latch well after the last rise of the serial clock
    latch_enable_line <= 1'h1;
    repeat (4) @(posedge clk);
    latch_enable_line <= 1'h0;
  endtask
endmodule
`default_nettype wire

// *** tb/pllcb_bank_asserts.sv ***
// Port-level checker for the synthesizer control register bank
`timescale 1ns/10ps
`default_nettype none
module pllcb_bank_asserts (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Watched inputs
  input  wire logic        latch_enable_line,
  // Watched outputs
  input  wire logic        mux_output_pin,
  input  wire logic [2:0]  cp_current_mult,
  input  wire logic        lo_drive_bit,
  input  wire logic        external_lo_bit,
  input  wire logic        lo_path_divider_bit,
  input  wire logic        external_lo_active,
  input  wire logic [2:0]  lo_mixer_divide,
  input  wire logic [4:0]  vco_amplitude,
  input  wire logic [6:0]  int_ratio,
  input  wire logic [10:0] modulus_value,
  input  wire logic [10:0] frac_value,
  input  wire logic [19:0] pll_ratio_num,
  input  wire logic        vco_cal_start
);
  logic       ld_q;   // Latch pin one cycle ago
  logic [3:0] age_q;  // Cycles since a latch rise, saturating
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Age restarts at reset so reset-value loading counts as recent
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_q <= 1'h0;
      age_q <= 4'h0;
    end else begin
      ld_q <= latch_enable_line;
      if (latch_enable_line && !ld_q) begin
        age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
        age_q <= age_q + 4'h1;
      end
    end
  end
  AST_CP_MULT_RANGE: assert property (cp_current_mult inside {[3'h1:3'h4]})
    else $error("pump multiplier out of range");
  AST_DIV_EXT: assert property (external_lo_active |->
    lo_mixer_divide == (lo_path_divider_bit ? 3'h4 : 3'h2)) else $error("external LO divide wrong");
  AST_DIV_INT: assert property (!external_lo_active |-> lo_mixer_divide == 3'h4)
    else $error("internal LO divide not four");
  AST_EXT_BITS: assert property (external_lo_active |-> !lo_drive_bit && external_lo_bit)
    else $error("external LO active with wrong bits");
  AST_CAL_ONE: assert property (vco_cal_start |=> !vco_cal_start)
    else $error("calibration pulse too long");
  AST_CAL_AFTER_LATCH: assert property (vco_cal_start |-> age_q >= 4'h1 && age_q <= 4'h6)
    else $error("calibration without a latched word");
  AST_AMP_ON_LATCH: assert property ($changed(vco_amplitude) |-> age_q <= 4'h8)
    else $error("amplitude changed without a latch");
  AST_RATIO: assert property (pll_ratio_num ==
    20'(2 * ($past(int_ratio) * $past(modulus_value) + $past(frac_value)))) else $error("ratio wrong");
  // Main scenarios reached
  COV_CAL: cover property (vco_cal_start);
  COV_EXT: cover property (external_lo_active);
  COV_MUX: cover property ($rose(mux_output_pin));
endmodule
bind pllcb_bank pllcb_bank_asserts u_chk (.clk, .rst_n, .latch_enable_line, .mux_output_pin, .cp_current_mult,
  .lo_drive_bit, .external_lo_bit, .lo_path_divider_bit, .external_lo_active, .lo_mixer_divide,
  .vco_amplitude, .int_ratio, .modulus_value, .frac_value, .pll_ratio_num, .vco_cal_start);
`default_nettype wire

// *** tb/pllcb_bank_bench.sv ***
// Self-checking bench for the synthesizer control register bank
`timescale 1ns/10ps
`default_nettype none
module pllcb_bank_bench;
  logic        clk, rst_n, ser_clk, ser_data, latch_enable_line;  // Clock, reset, link
  logic        loop_locked, lo_source_select_pin;                  // Status and strap
  logic [5:0]  band_calibration, vco_band;                         // Band values
  logic        mux_output_pin, cp_use_current_set_resistor, det_phase_offset_neg;
  logic [2:0]  cp_current_mult, lo_mixer_divide;
  logic [4:0]  det_phase_offset, vco_amplitude;
  logic [1:0]  ref_scale_sel;
  logic        lo_drive_bit, external_lo_bit, lo_path_divider_bit, lo_pre_poly_div2, demod_bias_en;
  logic        external_lo_active, vco_en, voltage_regulator_en, cp_en, vco_cal_start;
  logic [6:0]  int_ratio;
  logic [10:0] modulus_value, frac_value;
  logic [19:0] pll_ratio_num;
  int          fails, total_checks, cal_cnt;
  pllcb_bank dut (.clk, .rst_n, .ser_clk, .ser_data, .latch_enable_line, .loop_locked, .band_calibration,
    .lo_source_select_pin, .mux_output_pin, .cp_use_current_set_resistor, .cp_current_mult,
    .det_phase_offset, .det_phase_offset_neg, .ref_scale_sel, .lo_drive_bit, .external_lo_bit,
    .lo_path_divider_bit, .lo_pre_poly_div2, .demod_bias_en, .external_lo_active, .lo_mixer_divide,
    .vco_band, .vco_amplitude, .vco_en, .voltage_regulator_en, .cp_en, .int_ratio, .modulus_value,
    .frac_value, .pll_ratio_num, .vco_cal_start);
  pllcb_host_model host (.clk, .ser_clk, .ser_data, .latch_enable_line);
  // 50 ns clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Calibration pulses counted as they happen
  always @(posedge clk) begin
    if (vco_cal_start === 1'h1) cal_cnt++;
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  // Word plus time for the derived outputs to settle
  task automatic wr(input logic [23:0] w);
    host.send(w);
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset;
    loop_locked <= 1'h1;
    repeat (6) @(posedge clk);
    chk(mux_output_pin, 1'h1, "mux not lock after reset");
    chk(vco_amplitude, 5'h18, "amplitude reset");
    chk({vco_en, voltage_regulator_en, cp_en}, 3'h7, "enables reset");
    chk(cp_current_mult, 3'h1, "multiplier reset");
    chk(modulus_value, 11'h600, "modulus reset");
    loop_locked <= 1'h0;
    repeat (6) @(posedge clk);
    chk(mux_output_pin, 1'h0, "lock low not shown");
    $display("test reset done");
  endtask
  task automatic t_vco;
    band_calibration <= 6'h15;
    wr({6'h0, 1'h0, 1'h1, 1'h1, 5'h1f, 1'h1, 6'h2a, 3'h6});
    chk(vco_band, 6'h2a, "serial band");
    chk(vco_amplitude, 5'h1f, "amplitude max");
    chk({vco_en, voltage_regulator_en, cp_en}, 3'h0, "disables");
    wr({6'h0, 1'h1, 1'h0, 1'h0, 5'h00, 1'h0, 6'h2a, 3'h6});
    chk(vco_band, 6'h15, "calibrated band");
    chk({vco_amplitude, vco_en, voltage_regulator_en, cp_en}, 8'h07, "enables back");
    $display("test vco done");
  endtask
  task automatic t_lo;
    lo_source_select_pin <= 1'h0;
    wr({16'h0, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0, 3'h5});
    chk({demod_bias_en, lo_pre_poly_div2, lo_drive_bit}, 3'h6, "LO path bits");
    chk({lo_path_divider_bit, external_lo_bit}, 2'h1, "divider and external bits");
    chk({external_lo_active, lo_mixer_divide}, 4'ha, "ext LO by two");
    wr({16'h0, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 3'h5});
    chk({external_lo_active, lo_mixer_divide}, 4'hc, "ext LO by four");
    lo_source_select_pin <= 1'h1;
    repeat (8) @(posedge clk);
    chk({external_lo_active, lo_mixer_divide}, 4'h4, "internal LO");
    $display("test lo done");
  endtask
  task automatic t_cp_ref;
    logic [2:0] i;
    logic       mux_exp;
    loop_locked <= 1'h1;
    for (i = 3'h0; i < 3'h4; i++) begin
      wr({i, i[1:0], i[0], i[1], 5'(7 * i + 3), i[1:0], 7'h00, 3'h4});
      mux_exp = (i == 3'h0 || i == 3'h2);
      chk(mux_output_pin, mux_exp, "mux select");
      chk(cp_current_mult, i + 3'h1, "multiplier");
      chk(det_phase_offset, 5'(7 * i + 3), "phase offset");
      chk(det_phase_offset_neg, i[1], "offset sign");
      chk(ref_scale_sel, i[1:0], "reference scale");
      chk(cp_use_current_set_resistor, i[0], "current source");
    end
    // Codes 3 and 7 land nowhere
    wr(24'hff_ffff);
    wr(24'hff_fffb);
    chk({cp_current_mult, ref_scale_sel, det_phase_offset}, {3'h4, 2'h3, 5'h18}, "refused code");
    // Select code 3 still stands; pull the LO select pin low
    lo_source_select_pin <= 1'h0;
    repeat (8) @(posedge clk);
    chk(mux_output_pin, 1'h1, "mux shows external LO");
    $display("test charge pump done");
  endtask
  task automatic t_freq;
    cal_cnt = 0;
    wr({10'h0, 11'h0fa, 3'h2});
    wr({10'h0, 11'h3e8, 3'h1});
    wr({14'h0, 7'h77, 3'h0});
    wr({14'h0, 7'h77, 3'h0});
    chk(cal_cnt, 4, "calibration count");
    chk({int_ratio, frac_value}, {7'h77, 11'h0fa}, "int and frac");
    chk(modulus_value, 11'h3e8, "modulus");
    chk(pll_ratio_num, 20'h3_a3a4, "loop ratio");
    $display("test frequency done");
  endtask
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    fails++;
    complete_run();
  end
  initial begin
    rst_n = 1'h0;
    loop_locked = 1'h0;
    lo_source_select_pin = 1'h1;
    band_calibration = 6'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_vco();
    t_lo();
    t_cp_ref();
    t_freq();
    complete_run();
  end
endmodule
`default_nettype wire
